// ===== shared/ssc_pkg.sv
// Constants and types for the synchronous burst memory control block
package ssc_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam int LANES = 4;
    localparam int LANE_W = 8;
    localparam int WORDS = 65536;
    localparam int HI_W = ADDR_W - 2;
    localparam int BUF_DEPTH = 2;
    localparam logic [1:0] CNT_ONE = 2'h1;
    localparam logic [1:0] BUF_FULL = 2'h2;
    localparam logic [3:0] LANES_ALL = 4'hf;
    localparam logic [3:0] LANES_NONE = 4'h0;

    // Burst states, Gray coded
    typedef enum logic [1:0] {
        SSC_IDLE  = 2'h0,
        SSC_BURST = 2'h1,
        SSC_SLEEP = 2'h3
    } ssc_burst_t;

    // Pins captured on the rising edge
    typedef struct packed {
        logic              cs_n;
        logic              sec;
        logic              sec_n;
        logic              cpu_n;
        logic              ctl_n;
        logic              step_n;
        logic              all_n;
        logic              gate_n;
        logic [LANES-1:0]  lane_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              mode;
        logic              sleep;
    } ssc_in_t;

    // Whole block state
    typedef struct packed {
        ssc_in_t                         in;
        ssc_burst_t                      st;
        logic [HI_W-1:0]                 base_hi;
        logic [1:0]                      base_lo;
        logic [1:0]                      cnt;
        logic                            drive;
        logic [BUF_DEPTH-1:0][DATA_W-1:0] bdata;
        logic [1:0]                      bcount;
        logic                            head;
    } ssc_state_t;

    localparam ssc_in_t IN_RESET = '{
        cs_n: 1'b1, sec: 1'b0, sec_n: 1'b1, cpu_n: 1'b1, ctl_n: 1'b1,
        step_n: 1'b1, all_n: 1'b1, gate_n: 1'b1, lane_n: LANES_ALL,
        addr: '0, wdata: '0, mode: 1'b1, sleep: 1'b0};
endpackage

// ===== core/ssc_sram_ctrl.sv
// Control logic of a pipelined synchronous burst static memory
//
// What this block does
// - Array of 65,536 words, 32 bits each
// - Address, data, controls registered on rising edge
// - Write starts at edge, self-timed internally
// - Read data leaves through an output register
// - Two-bit counter drives low address bits
// - Mode high interleaved, mode low linear
// - Linear order increments low bits modulo four
// - Drive data only when awake, enable low
// - High impedance on write, deselect, sleep, disable
// - Data lines undriven from power-up
// - Global write all lanes, else gated lanes
// - Lane one is bits 7:0, upward
// - Processor strobe with selects starts read burst
// - Controller strobe starts write or read burst
// - Strobe with inactive select deselects, processor strobe only if primary select low
// - Low step advances counter when no start
// - High step repeats current burst address
// - Processor strobe ends burst in progress unless primary select high
`timescale 1ns/100ps
module ssc_sram_ctrl (
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       reset_n,
    // Selects and strobes
    input  wire logic                       chip_select_n,
    input  wire logic                       secondary_select,
    input  wire logic                       secondary_select_n,
    input  wire logic                       cpu_addr_strobe_n,
    input  wire logic                       ctrl_addr_strobe_n,
    input  wire logic                       burst_step_n,
    // Write enables
    input  wire logic                       all_bytes_write_n,
    input  wire logic                       byte_write_gate_n,
    input  wire logic [ssc_pkg::LANES-1:0]  lane_write_n,
    // Address and write data
    input  wire logic [ssc_pkg::ADDR_W-1:0] address,
    input  wire logic [ssc_pkg::DATA_W-1:0] data_lines_i,
    // Static and asynchronous controls
    input  wire logic                       burst_order_sel,
    input  wire logic                       flowthrough_tie_high,
    input  wire logic                       output_enable_n,
    input  wire logic                       sleep_request,
    // Data lines out
    output logic [ssc_pkg::DATA_W-1:0]      data_lines_o,
    output logic                            data_lines_oe,
    // Read stream and back-pressure
    output logic                            rd_valid,
    input  wire logic                       rd_ready,
    output logic [ssc_pkg::DATA_W-1:0]      rd_data,
    output logic                            req_ready
);
    import ssc_pkg::*;

    ssc_state_t s_q;
    ssc_state_t s_d;
    logic [DATA_W-1:0] mem [WORDS];
    logic [ADDR_W-1:0] op_addr;
    logic [LANES-1:0]  op_lanes;
    logic              op_valid;
    logic              stall;
    logic              sel_ok;
    logic              ld_p;
    logic              ld_c;
    logic              desel;
    logic              cont;
    logic              pop;
    logic              push;
    logic [LANES-1:0]  req_lanes;

    // Decode of the captured pins
    always_comb begin
        stall = (s_q.bcount == BUF_FULL); // Buffer full holds the pipeline
        sel_ok = !s_q.in.cs_n && s_q.in.sec && !s_q.in.sec_n;
        ld_p = sel_ok && !s_q.in.cpu_n;
        ld_c = sel_ok && s_q.in.cpu_n && !s_q.in.ctl_n;
        // Processor strobe ignored when primary select high
        desel = !sel_ok && (!s_q.in.ctl_n || (!s_q.in.cs_n && !s_q.in.cpu_n));
        cont = !ld_p && !ld_c && !desel && (s_q.st == SSC_BURST);
        if (!s_q.in.all_n) begin
            req_lanes = LANES_ALL;
        end else if (!s_q.in.gate_n) begin
            req_lanes = ~s_q.in.lane_n;
        end else begin
            req_lanes = LANES_NONE;
        end
    end

    // Next state of the whole block
    always_comb begin
        logic [1:0] lo;
        lo = '0;
        s_d = s_q;
        op_valid = 1'b0;
        op_lanes = LANES_NONE;
        pop = rd_valid && rd_ready;
        if (!stall) begin
            s_d.in = '{cs_n: chip_select_n, sec: secondary_select,
                       sec_n: secondary_select_n, cpu_n: cpu_addr_strobe_n,
                       ctl_n: ctrl_addr_strobe_n, step_n: burst_step_n,
                       all_n: all_bytes_write_n, gate_n: byte_write_gate_n,
                       lane_n: lane_write_n, addr: address,
                       wdata: data_lines_i, mode: burst_order_sel,
                       sleep: sleep_request};
        end
        if (s_q.in.sleep) begin
            s_d.st = SSC_SLEEP;
            s_d.drive = 1'b0;
        end else if (!stall) begin
            if (s_q.st == SSC_SLEEP) begin
                s_d.st = SSC_IDLE;
            end
            if (ld_p || ld_c) begin
                s_d.base_hi = s_q.in.addr[ADDR_W-1:2];
                s_d.base_lo = s_q.in.addr[1:0];
                s_d.cnt = '0;
                s_d.st = SSC_BURST;
                op_valid = 1'b1;
                op_lanes = ld_p ? LANES_NONE : req_lanes;
            end else if (desel) begin
                s_d.st = SSC_IDLE;
                s_d.drive = 1'b0;
            end else if (cont) begin
                if (!s_q.in.step_n) begin
                    s_d.cnt = s_q.cnt + CNT_ONE;
                end
                op_valid = 1'b1;
                op_lanes = req_lanes;
            end
        end
        // Burst order on the low two bits
        if (s_q.in.mode) begin
            lo = s_d.base_lo ^ s_d.cnt;
        end else begin
            lo = s_d.base_lo + s_d.cnt;
        end
        op_addr = {s_d.base_hi, lo};
        push = op_valid && (op_lanes == LANES_NONE);
        if (op_valid) begin
            s_d.drive = push;
        end
        // Two-entry read buffer
        if (push) begin
            s_d.bdata[s_q.head ^ s_q.bcount[0]] = mem[op_addr];
        end
        if (pop) begin
            s_d.head = !s_q.head;
        end
        s_d.bcount = s_q.bcount + {1'b0, push} - {1'b0, pop};
    end

    // Array write, finished within the cycle after capture
    always_ff @(posedge clk) begin
        if (op_valid) begin
            for (int i = 0; i < LANES; i++) begin
                if (op_lanes[i]) begin
                    mem[op_addr][i*LANE_W +: LANE_W] <= s_q.in.wdata[i*LANE_W +: LANE_W];
                end
            end
        end
    end

    // State register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '{in: IN_RESET, st: SSC_IDLE, base_hi: '0, base_lo: '0,
                     cnt: '0, drive: 1'b0, bdata: '0, bcount: '0,
                     head: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs; enable reacts to sleep and enable pins without clock
    assign rd_valid = (s_q.bcount != 2'h0);
    assign rd_data = s_q.bdata[s_q.head];
    assign data_lines_o = s_q.bdata[s_q.head];
    assign data_lines_oe = s_q.drive && rd_valid && !sleep_request
                           && !output_enable_n;
    assign req_ready = !stall;

    // Checks
    sequence start_seq;
        !stall && !s_q.in.sleep && (ld_p || ld_c);
    endsequence

    sequence step_seq;
        !stall && !s_q.in.sleep && cont && !s_q.in.step_n;
    endsequence

    oe_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
        (output_enable_n || sleep_request) |-> !data_lines_oe)
        else $error("data lines driven while disabled");

    reset_hiz_a: assert property (@(posedge clk)
        !reset_n |-> !data_lines_oe)
        else $error("data lines driven during reset");

    write_hiz_a: assert property (@(posedge clk) disable iff (!reset_n)
        (op_valid && op_lanes != LANES_NONE) |=> !data_lines_oe)
        else $error("data lines driven after write");

    desel_idle_a: assert property (@(posedge clk) disable iff (!reset_n)
        (desel && !stall && !s_q.in.sleep) |=> (s_q.st == SSC_IDLE) && !data_lines_oe)
        else $error("deselect did not idle");

    cpu_read_a: assert property (@(posedge clk) disable iff (!reset_n)
        (start_seq and ld_p) |-> op_lanes == LANES_NONE ##1 rd_valid)
        else $error("processor start not a read");

    start_cnt_a: assert property (@(posedge clk) disable iff (!reset_n)
        start_seq |=> (s_q.cnt == 2'h0) && (s_q.st == SSC_BURST))
        else $error("burst start did not load");

    step_next_a: assert property (@(posedge clk) disable iff (!reset_n)
        step_seq |=> s_q.cnt == $past(s_q.cnt) + CNT_ONE)
        else $error("step did not advance counter");

    hold_addr_a: assert property (@(posedge clk) disable iff (!reset_n)
        (cont && !stall && !s_q.in.sleep && s_q.in.step_n) |=> $stable(s_q.cnt))
        else $error("suspend changed address");

    order_a: assert property (@(posedge clk) disable iff (!reset_n)
        op_valid |-> op_addr[1:0] == (s_q.in.mode ? (s_d.base_lo ^ s_d.cnt)
                                     : 2'(s_d.base_lo + s_d.cnt)))
        else $error("burst order wrong");

    all_lanes_a: assert property (@(posedge clk) disable iff (!reset_n)
        (op_valid && !ld_p && !s_q.in.all_n) |-> op_lanes == LANES_ALL)
        else $error("global write not all lanes");

    sleep_idle_a: assert property (@(posedge clk) disable iff (!reset_n)
        s_q.in.sleep |-> !op_valid ##1 (s_q.st == SSC_SLEEP))
        else $error("operation during sleep");

    stall_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
        stall |-> !push ##1 $stable(s_q.in))
        else $error("captured pins lost during stall");

    // Head word stays put until the consumer takes it
    head_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
        (rd_valid && !pop) |=> $stable(rd_data))
        else $error("read head changed before pop");

    // Read operations and lane decode
    sequence read_op_seq;
        op_valid && (op_lanes == LANES_NONE);
    endsequence

    // Gated lanes follow the low lane enables
    lane_write_a: assert property (@(posedge clk) disable iff (!reset_n)
        (op_valid && !ld_p && s_q.in.all_n && !s_q.in.gate_n) |-> op_lanes == ~s_q.in.lane_n)
        else $error("lane enables not honoured");

    // Gate and global both high means read
    gate_read_a: assert property (@(posedge clk) disable iff (!reset_n)
        (op_valid && s_q.in.all_n && s_q.in.gate_n) |-> op_lanes == LANES_NONE)
        else $error("write without enable");

    // Controller start writes only when some enable is low
    ctl_write_a: assert property (@(posedge clk) disable iff (!reset_n)
        (start_seq and ld_c) |-> (op_lanes != LANES_NONE) == (!s_q.in.all_n
            || (!s_q.in.gate_n && (s_q.in.lane_n != LANES_ALL))))
        else $error("controller start type wrong");

    // Upper address bits fixed during a burst
    upper_fixed_a: assert property (@(posedge clk) disable iff (!reset_n)
        step_seq |-> op_addr[ADDR_W-1:2] == s_q.base_hi)
        else $error("upper address moved in burst");

    // First access of a burst uses the external address
    load_addr_a: assert property (@(posedge clk) disable iff (!reset_n)
        start_seq |-> op_addr == s_q.in.addr)
        else $error("start address not external");

    // Every read lands in the buffer
    read_push_a: assert property (@(posedge clk) disable iff (!reset_n)
        read_op_seq |=> rd_valid)
        else $error("read word not buffered");

    // Deselect performs no access
    desel_noop_a: assert property (@(posedge clk) disable iff (!reset_n)
        (desel && !stall && !s_q.in.sleep) |-> !op_valid)
        else $error("access while deselected");

    // Continue with no burst open does nothing
    idle_noop_a: assert property (@(posedge clk) disable iff (!reset_n)
        (!stall && (s_q.st != SSC_BURST) && !ld_p && !ld_c) |-> !op_valid)
        else $error("access without a burst");

    // Enabled read data is driven
    oe_follow_a: assert property (@(posedge clk) disable iff (!reset_n)
        (s_q.drive && rd_valid && !output_enable_n && !sleep_request) |-> data_lines_oe)
        else $error("read data not driven");

    // Lowest lane written from the low data byte
    low_lane_a: assert property (@(posedge clk) disable iff (!reset_n)
        (op_valid && op_lanes[0]) |=>
            mem[$past(op_addr)][LANE_W-1:0] == $past(s_q.in.wdata[LANE_W-1:0]))
        else $error("low lane write wrong");

    // Highest lane written from the top data byte
    high_lane_a: assert property (@(posedge clk) disable iff (!reset_n)
        (op_valid && op_lanes[LANES-1]) |=>
            mem[$past(op_addr)][DATA_W-1 -: LANE_W] == $past(s_q.in.wdata[DATA_W-1 -: LANE_W]))
        else $error("high lane write wrong");

    // Captured sleep turns drive off
    sleep_hiz_a: assert property (@(posedge clk) disable iff (!reset_n)
        s_q.in.sleep |=> !data_lines_oe)
        else $error("driven while asleep");

    // Last word taken empties the buffer
    drain_a: assert property (@(posedge clk) disable iff (!reset_n)
        (pop && !push && (s_q.bcount == 2'h1)) |=> !rd_valid)
        else $error("buffer empty flag wrong");

    // Second word fills the buffer and stalls capture
    full_stall_a: assert property (@(posedge clk) disable iff (!reset_n)
        ((s_q.bcount == 2'h1) && push && !pop) |=> !req_ready)
        else $error("buffer full flag wrong");

    // Frozen pipeline performs no access
    stall_noop_a: assert property (@(posedge clk) disable iff (!reset_n)
        stall |-> !op_valid)
        else $error("access during stall");

    // Writes clear the drive flag
    write_nodrive_a: assert property (@(posedge clk) disable iff (!reset_n)
        (op_valid && (op_lanes != LANES_NONE)) |=> !s_q.drive)
        else $error("drive left on after write");

    // Counter wraps after the fourth word
    linear_wrap_a: assert property (@(posedge clk) disable iff (!reset_n)
        (step_seq && (s_q.cnt == '1)) |=> (s_q.cnt == '0))
        else $error("burst counter did not wrap");

    // Interleaved low bits are start xor counter
    interleave_a: assert property (@(posedge clk) disable iff (!reset_n)
        (op_valid && s_q.in.mode) |-> (op_addr[1:0] ^ s_d.base_lo) == s_d.cnt)
        else $error("interleaved order wrong");
endmodule

// ===== testbench/ssc_host_model.sv
// Host-side model: read stream consumer and data line resolution
`timescale 1ns/100ps
module ssc_host_model (
    // Clock
    input  wire logic                      clk,
    // Read stream
    input  wire logic                      rd_valid,
    output logic                           rd_ready,
    // Host controls
    input  wire logic                      stall,
    input  wire logic                      host_oe,
    input  wire logic [ssc_pkg::DATA_W-1:0] host_data,
    // Data lines
    input  wire logic [ssc_pkg::DATA_W-1:0] data_lines_o,
    input  wire logic                      data_lines_oe,
    output logic [ssc_pkg::DATA_W-1:0]      data_lines_i
);
    import ssc_pkg::*;
    logic [DATA_W-1:0] last_q;
    // Consumer takes a word unless told to stall
    assign rd_ready = !stall;
    // Released lines show the inverse of their last level
    assign data_lines_i = data_lines_oe ? data_lines_o : (host_oe ? host_data : ~last_q);
    // Last level seen on the lines
    always_ff @(posedge clk) begin
        last_q <= data_lines_i;
    end
endmodule

// ===== testbench/test_sync_burst_sram_control.sv
// Self-checking bench for the burst memory control block
`timescale 1ns/100ps
module test_sync_burst_sram_control;
    import ssc_pkg::*;
    localparam logic [1:0] ON = 2'h2;
    logic              clk, reset_n, chip_select_n, secondary_select, secondary_select_n;
    logic              cpu_addr_strobe_n, ctrl_addr_strobe_n, burst_step_n, all_bytes_write_n;
    logic              byte_write_gate_n, burst_order_sel, flowthrough_tie_high, output_enable_n;
    logic              sleep_request, data_lines_oe, rd_valid, rd_ready, req_ready, stall, host_oe;
    logic [LANES-1:0]  lane_write_n;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] data_lines_i, data_lines_o, rd_data, host_data;
    logic [DATA_W-1:0] got[$];
    int                miscompares, total_checks, i;

    ssc_sram_ctrl u_dut (
        .clk(clk), .reset_n(reset_n), .chip_select_n(chip_select_n),
        .secondary_select(secondary_select), .secondary_select_n(secondary_select_n),
        .cpu_addr_strobe_n(cpu_addr_strobe_n), .ctrl_addr_strobe_n(ctrl_addr_strobe_n),
        .burst_step_n(burst_step_n), .all_bytes_write_n(all_bytes_write_n),
        .byte_write_gate_n(byte_write_gate_n), .lane_write_n(lane_write_n),
        .address(address), .data_lines_i(data_lines_i), .burst_order_sel(burst_order_sel),
        .flowthrough_tie_high(flowthrough_tie_high), .output_enable_n(output_enable_n),
        .sleep_request(sleep_request), .data_lines_o(data_lines_o),
        .data_lines_oe(data_lines_oe), .rd_valid(rd_valid), .rd_ready(rd_ready),
        .rd_data(rd_data), .req_ready(req_ready));
    ssc_host_model u_host (
        .clk(clk), .rd_valid(rd_valid), .rd_ready(rd_ready), .stall(stall),
        .host_oe(host_oe), .host_data(host_data), .data_lines_o(data_lines_o),
        .data_lines_oe(data_lines_oe), .data_lines_i(data_lines_i));

    // Free-running clock
    always #2.5 clk = ~clk;

    // Words taken by the host
    always @(posedge clk) begin
        if (rd_valid === 1'b1 && rd_ready === 1'b1) got.push_back(rd_data);
    end

    // Compare and count
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Counts and verdict
    task automatic close_out();
        $display("Checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Present one cycle of pins once the previous cycle was captured
    task automatic drive(input logic [1:0] sel, input logic cpu, ctl, stp, all, gate,
                         input logic [3:0] ln, input logic [15:0] a, input logic [31:0] d);
        int n;
        n = 0;
        while (req_ready !== 1'b1) begin
            @(posedge clk);
            #1;
            n++;
            if (n > 40) begin
                miscompares++;
                close_out();
            end
        end
        @(posedge clk);
        #1;
        {secondary_select, chip_select_n} = sel;
        {cpu_addr_strobe_n, ctrl_addr_strobe_n, burst_step_n} = {cpu, ctl, stp};
        {all_bytes_write_n, byte_write_gate_n, lane_write_n} = {all, gate, ln};
        address = a;
        host_data = d;
    endtask

    // Short forms: deselect, processor read, burst step
    task automatic idle();
        drive(2'h3, 1, 0, 1, 1, 1, 4'hf, 0, 0);
    endtask
    task automatic rd(input logic [15:0] a);
        drive(ON, 0, 1, 1, 1, 1, 4'hf, a, 0);
    endtask
    task automatic stp(input logic s);
        drive(ON, 1, 1, s, 1, 1, 4'hf, 0, 0);
    endtask

    // Take the next word the host received
    task automatic expect_word(input logic [31:0] exp);
        int n;
        n = 0;
        while (got.size() == 0) begin
            @(posedge clk);
            n++;
            if (n > 40) begin
                miscompares++;
                close_out();
            end
        end
        check("read word", got.pop_front(), exp);
    endtask

    // Reset in the chosen order mode, then fill four words
    task automatic restart(input logic mode);
        reset_n = 1'b0;
        burst_order_sel = mode;
        repeat (3) @(posedge clk);
        check("drive enable in reset", data_lines_oe, 0);
        #1;
        reset_n = 1'b1;
        output_enable_n = 1'b1;
        host_oe = 1'b1;
        for (i = 0; i < 4; i++) begin
            drive(ON, 1, 0, 1, 0, 1, 4'hf, 16'h1230 + i, 32'h0a0b0c00 + i);
        end
    endtask

    // Host side of a write is over
    task automatic end_writes();
        idle();
        host_oe = 1'b0;
        output_enable_n = 1'b0;
    endtask

    // Main sequence
    initial begin
        {clk, reset_n, stall, host_oe, sleep_request, burst_order_sel} = 6'h0;
        {chip_select_n, secondary_select, secondary_select_n} = 3'h6;
        {cpu_addr_strobe_n, ctrl_addr_strobe_n, burst_step_n} = 3'h7;
        {all_bytes_write_n, byte_write_gate_n, lane_write_n} = 6'h3f;
        {flowthrough_tie_high, output_enable_n} = 2'h3;
        address = 16'h0;
        host_data = 32'h0;
        miscompares = 0;
        total_checks = 0;
        restart(1'b0);
        drive(ON, 1, 0, 1, 1, 0, 4'hd, 16'h1231, 32'h55aa55aa);
        drive(ON, 1, 0, 1, 1, 1, 4'h0, 16'h1232, 32'hffffffff);
        end_writes();
        expect_word(32'h0a0b0c02);
        rd(16'h1233);
        for (i = 0; i < 3; i++) stp(1'b0);
        rd(16'h1232);
        stp(1'b0);
        rd(16'h1230);
        stp(1'b0);
        idle();
        expect_word(32'h0a0b0c03);
        expect_word(32'h0a0b0c00);
        expect_word(32'h0a0b5501);
        expect_word(32'h0a0b0c02);
        expect_word(32'h0a0b0c02);
        expect_word(32'h0a0b0c03);
        expect_word(32'h0a0b0c00);
        expect_word(32'h0a0b5501);
        $display("Linear order test done");
        restart(1'b1);
        end_writes();
        rd(16'h1232);
        for (i = 0; i < 3; i++) stp(1'b0);
        stp(1'b1);
        drive(2'h0, 0, 1, 1, 1, 1, 4'hf, 16'h1230, 0);
        stp(1'b0);
        sleep_request = 1'b1;
        rd(16'h1230);
        stp(1'b0);
        idle();
        sleep_request = 1'b0;
        repeat (6) @(posedge clk);
        expect_word(32'h0a0b0c02);
        expect_word(32'h0a0b0c03);
        expect_word(32'h0a0b0c00);
        expect_word(32'h0a0b0c01);
        expect_word(32'h0a0b0c01);
        check("stray words", 32'(got.size()), 0);
        $display("Interleaved, deselect and sleep test done");
        #1;
        stall = 1'b1;
        fork
            begin
                rd(16'h1232);
                for (i = 0; i < 3; i++) stp(1'b0);
                idle();
            end
            begin
                repeat (8) @(posedge clk);
                #1;
                check("request ready when full", req_ready, 0);
                check("head valid", rd_valid, 1);
                check("data lines", data_lines_i, 32'h0a0b0c02);
                output_enable_n = 1'b1;
                #1;
                check("drive enable, output off", data_lines_oe, 0);
                output_enable_n = 1'b0;
                sleep_request = 1'b1;
                #1;
                check("drive enable, asleep", data_lines_oe, 0);
                sleep_request = 1'b0;
                stall = 1'b0;
            end
        join
        expect_word(32'h0a0b0c02);
        expect_word(32'h0a0b0c03);
        expect_word(32'h0a0b0c00);
        expect_word(32'h0a0b0c01);
        repeat (3) @(posedge clk);
        #1;
        check("drained", rd_valid, 0);
        $display("Buffer stall test done");
        close_out();
    end
endmodule
